// ### hw/pcd_pkg.sv
// Package of constants for the progress code display and fault record block.
package pcd_pkg;

	// ----------------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------------
	localparam logic [11:0] OFS_CODE_LO  = 12'h000;
	localparam logic [11:0] OFS_CODE_HI  = 12'h004;
	localparam logic [11:0] OFS_CTRL     = 12'h008;
	localparam logic [11:0] OFS_RECORD0  = 12'h00C;
	localparam logic [11:0] OFS_RECORD1  = 12'h010;
	localparam logic [11:0] OFS_IRQ_STAT = 12'h014;
	localparam logic [11:0] OFS_IRQ_MASK = 12'h018;

	// ----------------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------------
	localparam int CTRL_TWO_BYTE_BIT = 0;
	localparam int CTRL_INCLUDE_BIT  = 1;
	localparam logic [1:0] CTRL_RESET = 2'h3;
	localparam int IRQ_RECORD_BIT = 0;
	localparam int IRQ_CODE_BIT   = 1;
	localparam int IRQ_WIDTH      = 2;

	// ----------------------------------------------------------------------
	// Fault record encodings
	// ----------------------------------------------------------------------
	localparam logic [3:0] SRC_CLASS      = 4'h3;
	localparam logic [2:0] FORMAT_REV     = 3'h0;
	localparam logic       SRC_IS_SW      = 1'b1;
	localparam logic [7:0] SENSOR_PROC    = 8'h07;
	localparam logic [7:0] TYPE_SPECIFIC  = 8'h6F;
	localparam logic [1:0] SPEC_OEM       = 2'h2;
	localparam logic [1:0] SPEC_NONE      = 2'h0;
	localparam logic [3:0] OFFSET_WDT     = 4'h3;
	localparam logic [7:0] DATA_UNSPEC    = 8'hFF;
	localparam logic [7:0] CODE_RESET     = 8'h00;

endpackage : pcd_pkg

// ### hw/pcd_display_record.sv
// Progress code capture, bicolour indicator drive and fault record assembly.
//
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/1ps

module pcd_display_record (
	input  wire logic        pclk,            // System clock, 25 MHz.
	input  wire logic        presetn,         // Asynchronous reset, active low.
	input  wire logic        clk_en,          // Clock enable, freezes all state when low.
	input  wire logic        io_wr_lo,        // Strobe: host writes low progress byte.
	input  wire logic        io_wr_hi,        // Strobe: host writes high progress byte.
	input  wire logic [7:0]  io_wdata,        // Byte written by the host.
	input  wire logic        boot_watchdog_fault, // Watchdog fault reset pin.
	input  wire logic        psel,            // APB select.
	input  wire logic        penable,         // APB enable.
	input  wire logic        pwrite,          // APB direction.
	input  wire logic [11:0] paddr,           // APB byte address.
	input  wire logic [31:0] pwdata,          // APB write data.
	output logic [31:0]      prdata,          // APB read data.
	output logic             pready,          // APB ready.
	output logic             pslverr,         // APB error on unmapped address.
	output logic [3:0]       led_red,         // Red elements, index 3 is leftmost (8).
	output logic [3:0]       led_green,       // Green elements, index 3 is leftmost (8).
	output logic             record_valid,    // Pulse: fault record bytes are new.
	output logic [7:0]       record_source_id, // Record source id byte.
	output logic [7:0]       record_sensor,   // Sensor type byte.
	output logic [7:0]       record_type,     // Event type code byte.
	output logic [7:0]       record_data1,    // Event data byte 1.
	output logic [7:0]       record_data2,    // Event data byte 2.
	output logic [7:0]       record_data3,    // Event data byte 3.
	output logic             irq              // Level interrupt, unmasked status set.
);

	// ----------------------------------------------------------------------
	// Pin synchroniser and fault edge detect
	// ----------------------------------------------------------------------
	logic fault_meta;
	logic fault_sync;
	logic fault_prev;
	logic fault_edge;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_meta <= 1'b0;
			fault_sync <= 1'b0;
			fault_prev <= 1'b0;
		end else if (clk_en) begin
			fault_meta <= boot_watchdog_fault;
			fault_sync <= fault_meta;
			fault_prev <= fault_sync;
		end
	end

	assign fault_edge = fault_sync & ~fault_prev;

	// ----------------------------------------------------------------------
	// Progress code capture
	// ----------------------------------------------------------------------
	logic [7:0] code_lo;
	logic [7:0] code_hi;
	logic       code_seen;

	// The host strobes come from logic on this clock, so they are read directly.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			code_lo   <= pcd_pkg::CODE_RESET;
			code_hi   <= pcd_pkg::CODE_RESET;
			code_seen <= 1'b0;
		end else if (clk_en) begin
			if (io_wr_lo) begin
				code_lo   <= io_wdata;
				code_seen <= 1'b1;
			end
			if (io_wr_hi) begin
				code_hi <= io_wdata;
			end
		end
	end

	// ----------------------------------------------------------------------
	// Bicolour indicators
	// ----------------------------------------------------------------------
	// Index 3 is the leftmost position seen from the rear and weighs 8.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			led_red   <= 4'h0;
			led_green <= 4'h0;
		end else if (clk_en) begin
			led_red   <= code_lo[7:4];
			led_green <= code_lo[3:0];
		end
	end

	// ----------------------------------------------------------------------
	// Control register
	// ----------------------------------------------------------------------
	logic [1:0] ctrl;
	logic       wr_en;
	logic       rd_en;
	logic       addr_ok;

	assign wr_en = psel & penable & pwrite;
	assign rd_en = psel & penable & ~pwrite;

	always_comb begin
		unique case (paddr)
			pcd_pkg::OFS_CODE_LO,
			pcd_pkg::OFS_CODE_HI,
			pcd_pkg::OFS_CTRL,
			pcd_pkg::OFS_RECORD0,
			pcd_pkg::OFS_RECORD1,
			pcd_pkg::OFS_IRQ_STAT,
			pcd_pkg::OFS_IRQ_MASK: addr_ok = 1'b1;
			default:               addr_ok = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= pcd_pkg::CTRL_RESET;
		end else if (clk_en) begin
			if (wr_en && paddr == pcd_pkg::OFS_CTRL) begin
				ctrl <= pwdata[1:0];
			end
		end
	end

	// ----------------------------------------------------------------------
	// Fault record assembly
	// ----------------------------------------------------------------------
	logic       spec;
	logic [7:0] next_data1;
	logic [7:0] next_data2;
	logic [7:0] next_data3;

	// Bytes are specified only when a code exists and inclusion is enabled.
	assign spec = code_seen & ctrl[pcd_pkg::CTRL_INCLUDE_BIT];

	always_comb begin
		if (spec) begin
			next_data1 = {pcd_pkg::SPEC_OEM, pcd_pkg::SPEC_OEM,
				pcd_pkg::OFFSET_WDT};
			next_data2 = code_lo;
			next_data3 = ctrl[pcd_pkg::CTRL_TWO_BYTE_BIT] ?
				code_hi : 8'h00;
		end else begin
			next_data1 = {pcd_pkg::SPEC_NONE, pcd_pkg::SPEC_NONE,
				pcd_pkg::OFFSET_WDT};
			next_data2 = pcd_pkg::DATA_UNSPEC;
			next_data3 = pcd_pkg::DATA_UNSPEC;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			record_valid     <= 1'b0;
			record_source_id <= 8'h00;
			record_sensor    <= 8'h00;
			record_type      <= 8'h00;
			record_data1     <= 8'h00;
			record_data2     <= 8'h00;
			record_data3     <= 8'h00;
		end else if (clk_en) begin
			record_valid <= fault_edge;
			if (fault_edge) begin
				record_source_id <= {pcd_pkg::SRC_CLASS, pcd_pkg::FORMAT_REV,
					pcd_pkg::SRC_IS_SW};
				record_sensor    <= pcd_pkg::SENSOR_PROC;
				record_type      <= pcd_pkg::TYPE_SPECIFIC;
				record_data1     <= next_data1;
				record_data2     <= next_data2;
				record_data3     <= next_data3;
			end
		end
	end

	// ----------------------------------------------------------------------
	// Interrupt status and mask
	// ----------------------------------------------------------------------
	logic [pcd_pkg::IRQ_WIDTH-1:0] irq_stat;
	logic [pcd_pkg::IRQ_WIDTH-1:0] irq_mask;
	logic [pcd_pkg::IRQ_WIDTH-1:0] irq_set;
	logic [pcd_pkg::IRQ_WIDTH-1:0] irq_clr;

	always_comb begin
		irq_set = '0;
		irq_set[pcd_pkg::IRQ_RECORD_BIT] = fault_edge;
		irq_set[pcd_pkg::IRQ_CODE_BIT]   = io_wr_lo | io_wr_hi;
	end

	assign irq_clr = (wr_en && paddr == pcd_pkg::OFS_IRQ_STAT) ?
		pwdata[pcd_pkg::IRQ_WIDTH-1:0] : '0;

	// A set in the same cycle as a clear wins.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat <= '0;
			irq_mask <= '0;
			irq      <= 1'b0;
		end else if (clk_en) begin
			irq_stat <= (irq_stat & ~irq_clr) | irq_set;
			if (wr_en && paddr == pcd_pkg::OFS_IRQ_MASK) begin
				irq_mask <= pwdata[pcd_pkg::IRQ_WIDTH-1:0];
			end
			irq <= |(((irq_stat & ~irq_clr) | irq_set) & irq_mask);
		end
	end

	// ----------------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------------
	logic [31:0] next_rdata;

	always_comb begin
		next_rdata = 32'h0000_0000;
		unique case (paddr)
			pcd_pkg::OFS_CODE_LO:  next_rdata = {24'h000000, code_lo};
			pcd_pkg::OFS_CODE_HI:  next_rdata = {24'h000000, code_hi};
			pcd_pkg::OFS_CTRL:     next_rdata = {30'h0, ctrl};
			pcd_pkg::OFS_RECORD0:  next_rdata = {record_data1, record_type,
				record_sensor, record_source_id};
			pcd_pkg::OFS_RECORD1:  next_rdata = {16'h0000, record_data3, record_data2};
			pcd_pkg::OFS_IRQ_STAT: next_rdata = {30'h0, irq_stat};
			pcd_pkg::OFS_IRQ_MASK: next_rdata = {30'h0, irq_mask};
			default:               next_rdata = 32'h0000_0000;
		endcase
	end

	// Ready is raised in the first access cycle and dropped after one cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else if (clk_en) begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~addr_ok;
			if (psel && !penable && !pwrite) begin
				prdata <= next_rdata;
			end
		end
	end

	// The register write above acts at the edge where pready is high; read data is captured at the setup-cycle edge before it.
	logic unused_rd;
	assign unused_rd = rd_en;

endmodule // pcd_display_record

// ### tb/pcd_monitor.sv
// Checker for the progress code display and fault record block.
`timescale 1ns/1ps

module pcd_monitor (
	input wire logic        pclk,                // Clock.
	input wire logic        presetn,             // Reset, active low.
	input wire logic        clk_en,              // Clock enable.
	input wire logic        io_wr_lo,            // Low byte strobe.
	input wire logic [7:0]  io_wdata,            // Host byte.
	input wire logic        boot_watchdog_fault, // Fault pin.
	input wire logic        psel,                // APB select.
	input wire logic        penable,             // APB enable.
	input wire logic        pready,              // APB ready.
	input wire logic [3:0]  led_red,             // Red elements.
	input wire logic [3:0]  led_green,           // Green elements.
	input wire logic        record_valid,        // Record pulse.
	input wire logic [7:0]  record_source_id,    // Source id byte.
	input wire logic [7:0]  record_sensor,       // Sensor type byte.
	input wire logic [7:0]  record_type,         // Type code byte.
	input wire logic [7:0]  record_data1,        // Data byte 1.
	input wire logic [7:0]  record_data2         // Data byte 2.
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic [7:0] lo_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			lo_q <= 8'h00;
		else if (io_wr_lo && clk_en)
			lo_q <= io_wdata;
	end

	sequence s_fault_rise;
		!boot_watchdog_fault ##1 boot_watchdog_fault;
	endsequence

	a_led_shows_code: assert property ({led_red, led_green} == $past(lo_q))
		else $error("indicators differ from last code");
	a_fault_makes_record: assert property (s_fault_rise |-> ##3 record_valid)
		else $error("no record after fault");
	a_no_stray_record: assert property (record_valid |-> $past(boot_watchdog_fault, 3)
		&& !$past(boot_watchdog_fault, 4)) else $error("record without fault edge");
	a_valid_one_cycle: assert property (record_valid |=> !record_valid)
		else $error("record pulse too long");
	a_record_fixed: assert property (record_valid |-> record_source_id == 8'h31
		&& record_sensor == pcd_pkg::SENSOR_PROC && record_type == 8'h6F)
		else $error("fixed record bytes wrong");
	a_data1_legal: assert property (record_valid |-> record_data1 inside {8'hA3, 8'h03})
		else $error("data byte 1 illegal");
	a_data2_code: assert property (record_valid && record_data1 == 8'hA3
		|-> record_data2 == lo_q) else $error("data byte 2 not low code");
	a_record_holds: assert property (!record_valid |-> $stable(record_data1)
		&& $stable(record_data2)) else $error("record bytes moved");
	a_apb_answer: assert property (psel && !penable |=> pready)
		else $error("no ready in access cycle");
endmodule // pcd_monitor

bind pcd_display_record pcd_monitor mon (.pclk, .presetn, .clk_en, .io_wr_lo, .io_wdata,
	.boot_watchdog_fault, .psel, .penable, .pready, .led_red, .led_green, .record_valid,
	.record_source_id, .record_sensor, .record_type, .record_data1, .record_data2);

// ### tb/pcd_host_model.sv
// Host model that writes progress bytes to the two code ports.
`timescale 1ns/1ps

module pcd_host_model (
	input  wire logic       pclk,     // Clock.
	output logic            io_wr_lo, // Low byte strobe.
	output logic            io_wr_hi, // High byte strobe.
	output logic [7:0]      io_wdata  // Byte written.
);
	initial begin
		io_wr_lo = 1'b0;
		io_wr_hi = 1'b0;
		io_wdata = 8'hA5;
	end

	// Released data lines show the inverse so stale bytes are never latched by luck.
	task automatic send(input logic two, input logic [7:0] lo, input logic [7:0] hi);
		@(posedge pclk);
		io_wr_lo <= 1'b1;
		io_wdata <= lo;
		if (two) begin
			@(posedge pclk);
			io_wr_lo <= 1'b0;
			io_wr_hi <= 1'b1;
			io_wdata <= hi;
		end
		@(posedge pclk);
		io_wr_lo <= 1'b0;
		io_wr_hi <= 1'b0;
		io_wdata <= two ? ~hi : ~lo;
	endtask
endmodule // pcd_host_model

// ### tb/pcd_display_record_test.sv
// Testbench for the progress code display and fault record block.
`timescale 1ns/1ps

module pcd_display_record_test;
	logic        pclk, presetn, clk_en, fault, psel, penable, pwrite, pready, pslverr;
	logic        io_wr_lo, io_wr_hi, record_valid, irq;
	logic [7:0]  io_wdata, src, sen, typ, d1, d2, d3;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0]  led_red, led_green;
	logic [7:0]  codes [6] = '{8'h95, 8'hF0, 8'h0F, 8'hFF, 8'h00, 8'h5A};
	int          num_errors = 0;
	int          n_checks = 0;

	pcd_display_record uut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
		.io_wr_lo(io_wr_lo), .io_wr_hi(io_wr_hi), .io_wdata(io_wdata),
		.boot_watchdog_fault(fault), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .led_red(led_red), .led_green(led_green),
		.record_valid(record_valid), .record_source_id(src), .record_sensor(sen),
		.record_type(typ), .record_data1(d1), .record_data2(d2), .record_data3(d3),
		.irq(irq));
	pcd_host_model host (.pclk(pclk), .io_wr_lo(io_wr_lo), .io_wr_hi(io_wr_hi),
		.io_wdata(io_wdata));

	// ----------------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			num_errors++;
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20)
			num_errors++;
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		chk(r, x);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic flt(input logic [7:0] x1, input logic [7:0] x2, input logic [7:0] x3);
		int k;
		@(posedge pclk);
		fault <= 1'b1;
		k = 0;
		do begin
			@(negedge pclk);
			k++;
		end while (record_valid !== 1'b1 && k < 10);
		chk({7'h00, record_valid, src, sen, typ}, 32'h0131076F);
		chk({8'h00, d1, d2, d3}, {8'h00, x1, x2, x3});
		@(posedge pclk);
		fault <= 1'b0;
		repeat (4) @(posedge pclk);
	endtask

	task automatic print_verdict;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ----------------------------------------------------------------------
	// Clock, watchdog and tests
	// ----------------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	initial begin
		#100000;
		num_errors++;
		print_verdict;
	end

	initial begin
		logic [31:0] r;
		logic        e;
		presetn = 1'b0;
		clk_en = 1'b1;
		fault = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(pcd_pkg::OFS_CTRL, 32'h3);
		rd(pcd_pkg::OFS_IRQ_MASK, 32'h0);
		apb(1'b0, 12'hFFC, 32'h0, r, e);
		chk({31'h0, e}, 32'h1);
		chk(r, 32'h0);
		wr(pcd_pkg::OFS_IRQ_MASK, 32'h3);
		flt(8'h03, 8'hFF, 8'hFF);
		@(negedge pclk);
		chk({31'h0, irq}, 32'h1);
		wr(pcd_pkg::OFS_IRQ_STAT, 32'h1);
		rd(pcd_pkg::OFS_IRQ_STAT, 32'h0);
		for (int i = 0; i < 6; i++) begin
			host.send(1'b0, codes[i], 8'h00);
			repeat (3) @(negedge pclk);
			chk({led_red, led_green}, codes[i]);
		end
		rd(pcd_pkg::OFS_IRQ_STAT, 32'h2);
		wr(pcd_pkg::OFS_CODE_LO, 32'hFF);
		rd(pcd_pkg::OFS_CODE_LO, 32'h5A);
		host.send(1'b1, 8'h42, 8'h19);
		flt(8'hA3, 8'h42, 8'h19);
		rd(pcd_pkg::OFS_RECORD0, 32'hA36F0731);
		rd(pcd_pkg::OFS_RECORD1, 32'h1942);
		wr(pcd_pkg::OFS_CTRL, 32'h2);
		flt(8'hA3, 8'h42, 8'h00);
		wr(pcd_pkg::OFS_CTRL, 32'h0);
		flt(8'h03, 8'hFF, 8'hFF);
		print_verdict;
	end
endmodule // pcd_display_record_test
